// ### i2c_slave_wiper_port.sv
// i2c slave front end giving read and write access to the wiper
`include "i2c_wiper_params.svh"

module i2c_slave_wiper_port #(
    parameter int FILT_CYC = `I2CW_GLITCH_CYC  // deglitch length, cycles
) (
    input  wire logic       clock,      // 40 MHz system clock
    input  wire logic       rst_b,      // synchronous reset, active low
    input  wire logic       sclIn,      // scl level seen on the pin
    input  wire logic       sdaIn,      // sda level seen on the pin
    output logic            sdaOut,     // sda value when driven
    output logic            sdaOe,      // high while pulling sda low
    output logic            sclOut,     // scl value when driven
    output logic            sclOe,      // scl enable, stays low
    output logic [6:0]      wiperOut,   // current wiper setting
    output logic            dataValid,  // written byte available
    output logic [6:0]      dataWord,   // oldest written byte
    input  wire logic       dataReady   // consumer takes dataWord
);

    // counter is four bits wide, so longer filters cannot be served
    if (FILT_CYC < 1 || FILT_CYC > 15) begin : g_bad_filt
        $error("FILT_CYC must lie between 1 and 15");
    end

    // last count before a new level is believed
    localparam logic [3:0] FILT_LAST = 4'(FILT_CYC - 1);

    // bus line indices inside the two-bit line vectors
    localparam int SCL = 0;
    localparam int SDA = 1;

    i2c_wiper_pkg::state_t st_ff;   // registered state
    i2c_wiper_pkg::state_t nxt_st;  // next state

    // decode of the control byte address, used in the PH_ADDR branch
    function automatic logic addrIsOurs(input logic [7:0] ctl);
        addrIsOurs = (ctl[7:1] == `I2CW_SLAVE_ADDR);
    endfunction

    // general call is matched on its own so it can never be acked
    function automatic logic addrIsGcall(input logic [7:0] ctl);
        addrIsGcall = (ctl[7:1] == `I2CW_GCALL_ADDR);
    endfunction

    // next-state logic: sync, filter, bus events, phases, buffer
    always_comb begin
        logic [1:0] lineIn;     // raw pin levels
        logic       sclRise;    // filtered scl rising
        logic       sclFall;    // filtered scl falling
        logic       sdaNow;     // filtered sda level
        logic       startDet;   // start or repeated start seen
        logic       stopDet;    // stop seen
        logic       pushReq;    // accepted byte enters the buffer
        logic       popReq;     // consumer takes the head word
        logic       roomFree;   // buffer can take one more word
        lineIn   = {sdaIn, sclIn};
        sclRise  = 1'b0;
        sclFall  = 1'b0;
        sdaNow   = 1'b0;
        startDet = 1'b0;
        stopDet  = 1'b0;
        pushReq  = 1'b0;
        popReq   = 1'b0;
        roomFree = 1'b0;
        nxt_st   = st_ff;

        // two flops then a stability filter on each line
        for (int i = 0; i < 2; i++) begin
            nxt_st.syncA[i] = lineIn[i];
            nxt_st.syncB[i] = st_ff.syncA[i];
            if (st_ff.syncB[i] == st_ff.filt[i]) begin
                // agreement: any spike so far is forgotten
                nxt_st.glitch[i] = 4'h0;
            end else if (st_ff.glitch[i] == FILT_LAST) begin
                // new level held long enough to be real
                nxt_st.filt[i]   = st_ff.syncB[i];
                nxt_st.glitch[i] = 4'h0;
            end else begin
                nxt_st.glitch[i] = st_ff.glitch[i] + 4'h1;
            end
        end
        nxt_st.prevFilt = st_ff.filt;

        // edges and conditions on the filtered lines
        sclRise = st_ff.filt[SCL] & ~st_ff.prevFilt[SCL];
        sclFall = ~st_ff.filt[SCL] & st_ff.prevFilt[SCL];
        sdaNow  = st_ff.filt[SDA];
        // both scl samples high so an scl edge is never taken as one
        startDet = st_ff.filt[SCL] & st_ff.prevFilt[SCL] &
                   st_ff.prevFilt[SDA] & ~st_ff.filt[SDA];
        stopDet  = st_ff.filt[SCL] & st_ff.prevFilt[SCL] &
                   ~st_ff.prevFilt[SDA] & st_ff.filt[SDA];

        // buffer drain side; a stalled consumer fills it up
        popReq   = st_ff.fifo.headVal & dataReady;
        // room judged before this cycle's pop, the safe side
        roomFree = ~st_ff.fifo.tailVal;

        // serial phase machine; sda only moves on scl falling edges
        case (st_ff.phase)
            i2c_wiper_pkg::PH_IDLE: begin
                // static: released, only a start wakes us
                nxt_st.sdaOe = 1'b0;
            end
            i2c_wiper_pkg::PH_ADDR,
            i2c_wiper_pkg::PH_WRDATA: begin
                if (sclRise && st_ff.bitCnt < `I2CW_BYTE_BITS) begin
                    // msb first: shift the new bit in at the bottom
                    nxt_st.shift  = {st_ff.shift[6:0], sdaNow};
                    nxt_st.bitCnt = st_ff.bitCnt + 4'h1;
                end else if (sclFall &&
                             st_ff.bitCnt == `I2CW_BYTE_BITS) begin
                    if (st_ff.phase == i2c_wiper_pkg::PH_ADDR) begin
                        if (addrIsOurs(st_ff.shift) &&
                            !addrIsGcall(st_ff.shift)) begin
                            // our address: pull sda for the ack clock
                            nxt_st.sdaOe = 1'b1;
                            nxt_st.rw    = st_ff.shift[`I2CW_RW_BIT];
                            nxt_st.phase = i2c_wiper_pkg::PH_ACK;
                        end else begin
                            // other or general call: stay released
                            nxt_st.sdaOe = 1'b0;
                            nxt_st.phase = i2c_wiper_pkg::PH_IGNORE;
                        end
                    end else if (roomFree) begin
                        // data byte accepted; lands on the ack clock
                        nxt_st.sdaOe      = 1'b1;
                        nxt_st.commitPend = 1'b1;
                        nxt_st.phase      = i2c_wiper_pkg::PH_ACK;
                    end else begin
                        // no clock stretching, so a full buffer can
                        // only refuse the byte with a not-acknowledge
                        nxt_st.sdaOe = 1'b0;
                        nxt_st.phase = i2c_wiper_pkg::PH_IGNORE;
                    end
                end
            end
            i2c_wiper_pkg::PH_ACK: begin
                if (sclRise && st_ff.commitPend) begin
                    // ack clock reached: the byte is now committed
                    nxt_st.wiper      = st_ff.shift[6:0];
                    nxt_st.commitPend = 1'b0;
                    pushReq           = 1'b1;
                end else if (sclFall) begin
                    nxt_st.bitCnt = 4'h0;
                    if (st_ff.rw) begin
                        // read: first data bit goes out right away
                        nxt_st.shift = {1'b0, st_ff.wiper};
                        nxt_st.sdaOe = 1'b1;
                        nxt_st.phase = i2c_wiper_pkg::PH_RDDATA;
                    end else begin
                        nxt_st.sdaOe = 1'b0;
                        nxt_st.phase = i2c_wiper_pkg::PH_WRDATA;
                    end
                end
            end
            i2c_wiper_pkg::PH_RDDATA: begin
                if (sclRise) begin
                    if (!st_ff.sdaOe && !sdaNow) begin
                        // we released a one yet the line is low:
                        // another driver owns the bus, drop out
                        nxt_st.sdaOe = 1'b0;
                        nxt_st.phase = i2c_wiper_pkg::PH_IGNORE;
                    end
                    nxt_st.bitCnt = st_ff.bitCnt + 4'h1;
                end else if (sclFall) begin
                    if (st_ff.bitCnt == `I2CW_BYTE_BITS) begin
                        // byte out: release for the master's answer
                        nxt_st.sdaOe = 1'b0;
                        nxt_st.phase = i2c_wiper_pkg::PH_RDACK;
                    end else begin
                        nxt_st.shift = {st_ff.shift[6:0], 1'b0};
                        nxt_st.sdaOe = ~st_ff.shift[`I2CW_MSB_BIT - 1];
                    end
                end
            end
            i2c_wiper_pkg::PH_RDACK: begin
                if (sclRise && sdaNow) begin
                    // master nack: last byte, let go of the bus
                    nxt_st.sdaOe = 1'b0;
                    nxt_st.phase = i2c_wiper_pkg::PH_IGNORE;
                end else if (sclFall) begin
                    // master ack: send the wiper once more
                    nxt_st.bitCnt = 4'h0;
                    nxt_st.shift  = {1'b0, st_ff.wiper};
                    nxt_st.sdaOe  = 1'b1;
                    nxt_st.phase  = i2c_wiper_pkg::PH_RDDATA;
                end
            end
            i2c_wiper_pkg::PH_IGNORE: begin
                // passive high until a start and a control byte
                nxt_st.sdaOe = 1'b0;
            end
            default: begin
                nxt_st.sdaOe = 1'b0;
                nxt_st.phase = i2c_wiper_pkg::PH_IDLE;
            end
        endcase

        // start anywhere restarts the control byte; a pending
        // write is dropped so an aborted byte never lands
        if (startDet) begin
            nxt_st.phase      = i2c_wiper_pkg::PH_ADDR;
            nxt_st.bitCnt     = 4'h0;
            nxt_st.sdaOe      = 1'b0;
            nxt_st.commitPend = 1'b0;
            nxt_st.rw         = 1'b0;
            pushReq           = 1'b0;
            nxt_st.wiper      = st_ff.wiper;
        end else if (stopDet) begin
            nxt_st.phase      = i2c_wiper_pkg::PH_IDLE;
            nxt_st.bitCnt     = 4'h0;
            nxt_st.sdaOe      = 1'b0;
            nxt_st.commitPend = 1'b0;
            pushReq           = 1'b0;
            nxt_st.wiper      = st_ff.wiper;
        end

        // scl is input only, and the open-drain value is always low
        nxt_st.sclOe   = 1'b0;
        nxt_st.lineVal = 1'b0;

        // two-entry buffer: pop moves tail forward, push fills a gap
        if (popReq) begin
            nxt_st.fifo.headVal = st_ff.fifo.tailVal;
            nxt_st.fifo.head    = st_ff.fifo.tail;
            nxt_st.fifo.tailVal = 1'b0;
        end
        if (pushReq) begin
            if (!nxt_st.fifo.headVal) begin
                nxt_st.fifo.headVal = 1'b1;
                nxt_st.fifo.head    = st_ff.shift[6:0];
            end else begin
                nxt_st.fifo.tailVal = 1'b1;
                nxt_st.fifo.tail    = st_ff.shift[6:0];
            end
        end
    end

    // state register; lines start at the idle high level
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st_ff          <= '0;
            st_ff.syncA    <= `I2CW_LINE_IDLE;
            st_ff.syncB    <= `I2CW_LINE_IDLE;
            st_ff.filt     <= `I2CW_LINE_IDLE;
            st_ff.prevFilt <= `I2CW_LINE_IDLE;
            st_ff.phase    <= i2c_wiper_pkg::PH_IDLE;
            st_ff.wiper    <= `I2CW_WIPER_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs come straight from the state register
    assign sdaOut    = st_ff.lineVal;
    assign sdaOe     = st_ff.sdaOe;
    assign sclOut    = st_ff.lineVal;
    assign sclOe     = st_ff.sclOe;
    assign wiperOut  = st_ff.wiper;
    assign dataValid = st_ff.fifo.headVal;
    assign dataWord  = st_ff.fifo.head;

endmodule // i2c_slave_wiper_port

// ### i2c_wiper_params.svh
// constants for the i2c wiper port: address, reset values, timing
`ifndef I2C_WIPER_PARAMS_SVH
`define I2C_WIPER_PARAMS_SVH

// fixed seven-bit slave address, no pin-selectable bits
`define I2CW_SLAVE_ADDR   7'h2f
// general call address, always refused
`define I2CW_GCALL_ADDR   7'h00
// wiper value loaded at power-up reset
`define I2CW_WIPER_RST    7'h3f
// idle level of both bus lines
`define I2CW_LINE_IDLE    2'h3
// number of clock edges in a byte before the acknowledge slot
`define I2CW_BYTE_BITS    4'h8
// position of the direction flag in the control byte
`define I2CW_RW_BIT       0
// position of the top bit of a byte, the first one on the wire
`define I2CW_MSB_BIT      7

// system clock period in ns
`define I2CW_CLK_NS       25
// least time a line must stay at a new level to be believed, ns
`define I2CW_GLITCH_NS    50
// least time rounds up to whole clock cycles, never below one
`define I2CW_GLITCH_CYC \
    (((`I2CW_GLITCH_NS + `I2CW_CLK_NS - 1) / `I2CW_CLK_NS) < 1 ? 1 : \
     ((`I2CW_GLITCH_NS + `I2CW_CLK_NS - 1) / `I2CW_CLK_NS))

`endif

// ### i2c_wiper_pkg.sv
// types shared by the i2c wiper port: phase enum and state struct
package i2c_wiper_pkg;

    // serial interface phases
    typedef enum logic [2:0] {
        PH_IDLE   = 3'h0,   // released, waiting for a start
        PH_ADDR   = 3'h1,   // shifting in the control byte
        PH_ACK    = 3'h2,   // holding sda low for an acknowledge
        PH_WRDATA = 3'h3,   // shifting in a write data byte
        PH_RDDATA = 3'h4,   // shifting out wiper data
        PH_RDACK  = 3'h5,   // sampling the master's acknowledge
        PH_IGNORE = 3'h6    // fallen off the bus until next start
    } phase_t;

    // two-entry output buffer for accepted write bytes
    typedef struct packed {
        logic       headVal;   // head entry holds a word
        logic [6:0] head;      // head word, seen at the output
        logic       tailVal;   // tail entry holds a word
        logic [6:0] tail;      // tail word
    } buf_t;

    // all state of the port in one register
    typedef struct packed {
        logic [1:0]      syncA;    // first sync stage, {sda, scl}
        logic [1:0]      syncB;    // second sync stage
        logic [1:0][3:0] glitch;   // per-line disagreement counters
        logic [1:0]      filt;     // filtered line levels
        logic [1:0]      prevFilt; // filtered levels one cycle ago
        phase_t          phase;    // serial interface phase
        logic [3:0]      bitCnt;   // bits seen in the current byte
        logic [7:0]      shift;    // receive or transmit shifter
        logic            rw;       // direction flag of control byte
        logic            commitPend; // write byte waits for ack clock
        logic            sdaOe;    // pulling sda low
        logic            sclOe;    // pulling scl low, never set
        logic            lineVal;  // value driven when enabled
        logic [6:0]      wiper;    // volatile wiper register
        buf_t            fifo;     // accepted write bytes
    } state_t;

endpackage

// ### i2c_wiper_port_monitor.sv
// concurrent checks on the ports of the i2c wiper port
module i2c_wiper_port_monitor #(
    parameter int FILT_CYC = 2  // deglitch length, cycles
) (
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic       sclIn,
    input wire logic       sdaIn,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic       sclOut,
    input wire logic       sclOe,
    input wire logic [6:0] wiperOut,
    input wire logic       dataValid,
    input wire logic [6:0] dataWord,
    input wire logic       dataReady
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // clock line is never pulled
    property p_sclFree; !sclOe; endproperty
    a_sclFree: assert property (p_sclFree)
        else $error("scl enable raised");
    // only ever pull sda low
    property p_sdaLow; sdaOe |-> !sdaOut; endproperty
    a_sdaLow: assert property (p_sdaLow)
        else $error("sda driven high");
    // values seen right after reset release
    property p_rstVal;
        $rose(rst_b) |-> wiperOut == 7'h3f && !dataValid && !sdaOe;
    endproperty
    a_rstVal: assert property (p_rstVal)
        else $error("bad value after reset");
    // sda drive moves only after an scl fall; sync and filter delay
    // it three cycles at the shortest filter, four at the default
    property p_sdaChg;
        $changed(sdaOe) |-> !$past(sclIn, 3) || !$past(sclIn, 4);
    endproperty
    a_sdaChg: assert property (p_sdaChg)
        else $error("sda drive moved with scl high");
    // an acknowledge or data low stands a whole scl period
    property p_ackHold; $rose(sdaOe) |-> sdaOe [*7]; endproperty
    a_ackHold: assert property (p_ackHold)
        else $error("sda pull too short");
    // wiper only lands on the ack clock high phase
    property p_wiperAck;
        $changed(wiperOut) |-> $past(sclIn, 3) || $past(sclIn, 4)
            || $past(sclIn, 5);
    endproperty
    a_wiperAck: assert property (p_wiperAck)
        else $error("wiper moved outside ack clock");
    // each committed word enters the buffer in the cycle it lands, so dataValid is high; a ready
    // consumer may already take the head word at the next edge
    property p_wiperPush; $changed(wiperOut) |-> dataValid; endproperty
    a_wiperPush: assert property (p_wiperPush)
        else $error("written word not offered");
    // a stalled head word is held
    property p_headHold;
        dataValid && !dataReady |=> dataValid && $stable(dataWord);
    endproperty
    a_headHold: assert property (p_headHold)
        else $error("head word lost under stall");
    // after a stop the line stays released
    property p_stopIdle;
        $rose(sdaIn) && sclIn && $past(sclIn) |=> !sdaOe [*8];
    endproperty
    a_stopIdle: assert property (p_stopIdle)
        else $error("sda pulled after stop");
endmodule // i2c_wiper_port_monitor

bind i2c_slave_wiper_port i2c_wiper_port_monitor #(
    .FILT_CYC(FILT_CYC)
) u_monitor (
    .clock(clock), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .sclOut(sclOut), .sclOe(sclOe),
    .wiperOut(wiperOut), .dataValid(dataValid), .dataWord(dataWord),
    .dataReady(dataReady)
);

// ### i2c_master_model.sv
// behavioural i2c bus master that drives scl and shares sda
module i2c_master_model (
    input  wire logic clock,    // system clock, used as time base
    output logic      scl,      // scl line, idle high between frames
    output logic      sdaDrv,   // master side of sda, 1 = released
    input  wire logic sdaWire   // resolved sda line
);
    timeunit 1ns;
    timeprecision 100ps;

    // lines released at time zero, pull-ups keep them high
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end

    // advance n cycles, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // start or repeated start, sda falls with scl high
    task automatic start();
        tick(2);
        sdaDrv = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(3);
        sdaDrv = 1'b0;
        tick(3);
        scl = 1'b0;
    endtask

    // stop, sda rises with scl high, then scl stays still
    task automatic stop();
        tick(2);
        sdaDrv = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(3);
        sdaDrv = 1'b1;
        tick(4);
    endtask

    // one bit: 5 cycles low, 3 high; sda moves mid low phase only
    task automatic bitio(input logic b, output logic r);
        tick(2);
        sdaDrv = b;
        tick(3);
        scl = 1'b1;
        tick(2);
        r = sdaWire;  // late in high phase, after slave settles
        tick(1);
        scl = 1'b0;
    endtask

    // byte msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ackOut,
                        output logic [7:0] rx, output logic ackIn);
        for (int i = 7; i >= 0; i--)
            bitio(tx[i], rx[i]);
        bitio(ackOut, ackIn);
    endtask
endmodule // i2c_master_model

// ### i2c_slave_wiper_port_tb.sv
// self-checking bench for the i2c wiper port
module i2c_slave_wiper_port_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clock = 1'b0;      // 40 MHz
    logic       rst_b = 1'b0;      // held low at start
    logic       sclIn;             // from master model
    logic       sdaM;              // master side of sda
    logic       sdaIn;             // resolved sda wire
    logic       sdaOut, sdaOe, sclOut, sclOe, dataValid;
    logic       dataReady = 1'b1;  // consumer, stalled in one test
    logic [6:0] wiperOut, dataWord;
    logic [6:0] popped[$];         // words taken by the consumer
    int         error_cnt = 0;
    int         check_count = 0;

    always #12.5 clock = ~clock;
    // open drain: either party pulling low wins
    assign sdaIn = sdaM & ~sdaOe;
    // consumer records every accepted word
    always @(posedge clock)
        if (dataValid === 1'b1 && dataReady === 1'b1)
            popped.push_back(dataWord);

    i2c_slave_wiper_port #(.FILT_CYC(1)) u_dut (
        .clock(clock), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .sclOut(), .sclOe(sclOe),
        .wiperOut(wiperOut), .dataValid(dataValid),
        .dataWord(dataWord), .dataReady(dataReady));
    i2c_master_model u_master (
        .clock(clock), .scl(sclIn), .sdaDrv(sdaM), .sdaWire(sdaIn));

    // compare one bit
    task automatic chkBit(input logic exp, input logic act);
        check_count++;
        if (act !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: exp %h got %h", $time, exp, act);
        end
    endtask
    // compare one byte
    task automatic chkData(input logic [7:0] exp, input logic [7:0] act);
        check_count++;
        if (act !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: exp %h got %h", $time, exp, act);
        end
    endtask
    // words handed to the consumer, oldest first
    task automatic chkPops(input logic [6:0] w0, input logic [6:0] w1);
        chkData(8'h02, 8'(popped.size()));
        if (popped.size() == 2) begin
            chkData({1'b0, w0}, {1'b0, popped[0]});
            chkData({1'b0, w1}, {1'b0, popped[1]});
        end
        popped.delete();
    endtask

    task automatic test_reset();
        chkData(8'h3f, {1'b0, wiperOut});
        chkBit(1'b0, dataValid);
        chkBit(1'b0, sclOe);
        $display("test reset done");
    endtask

    // two data bytes in one write, top bit dropped
    task automatic test_write();
        logic [7:0] rx;
        logic       a;
        u_master.start();
        u_master.xfer(8'h5e, 1'b1, rx, a);
        chkBit(1'b0, a);
        u_master.xfer(8'h80, 1'b1, rx, a);
        chkBit(1'b0, a);
        u_master.xfer(8'hd5, 1'b1, rx, a);
        chkBit(1'b0, a);
        u_master.stop();
        chkData(8'h55, {1'b0, wiperOut});
        chkPops(7'h00, 7'h55);
        $display("test write done");
    endtask

    // read two bytes, master nacks the last
    task automatic test_read();
        logic [7:0] rx;
        logic       a;
        u_master.start();
        u_master.xfer(8'h5f, 1'b1, rx, a);
        chkBit(1'b0, a);
        u_master.xfer(8'hff, 1'b0, rx, a);
        chkData(8'h55, rx);
        u_master.xfer(8'hff, 1'b1, rx, a);
        chkData(8'h55, rx);
        chkBit(1'b0, sdaOe);
        u_master.stop();
        $display("test read done");
    endtask

    // foreign and general call addresses, then a byte that is ignored
    task automatic test_refuse();
        logic [7:0] rx;
        logic       a;
        logic [7:0] ctl[3] = '{8'h5c, 8'h00, 8'h5d};
        foreach (ctl[i]) begin
            u_master.start();
            u_master.xfer(ctl[i], 1'b1, rx, a);
            chkBit(1'b1, a);
            u_master.xfer(8'h11, 1'b1, rx, a);
            chkBit(1'b1, a);
            u_master.stop();
        end
        chkData(8'h55, {1'b0, wiperOut});
        $display("test refuse done");
    endtask

    // start and stop in mid byte both discard it
    task automatic test_abort();
        logic [7:0] rx;
        logic       a;
        logic       r;
        u_master.start();
        u_master.xfer(8'h5e, 1'b1, rx, a);
        repeat (4) u_master.bitio(1'b0, r);
        u_master.start();
        u_master.xfer(8'h5e, 1'b1, rx, a);
        chkBit(1'b0, a);
        repeat (5) u_master.bitio(1'b0, r);
        u_master.stop();
        chkData(8'h55, {1'b0, wiperOut});
        chkData(8'h00, 8'(popped.size()));
        $display("test abort done");
    endtask

    // recovery by a start in the second data bit of a read, a one bit for which the device has released sda
    task automatic test_recover();
        logic [7:0] rx;
        logic       a;
        logic       r;
        u_master.start();
        u_master.xfer(8'h5f, 1'b1, rx, a);
        u_master.bitio(1'b1, r);
        u_master.start();
        repeat (9) u_master.bitio(1'b1, r);
        u_master.start();
        u_master.stop();
        chkBit(1'b0, sdaOe);
        chkData(8'h55, {1'b0, wiperOut});
        u_master.start();
        u_master.xfer(8'h5e, 1'b1, rx, a);
        chkBit(1'b0, a);
        u_master.stop();
        $display("test recover done");
    endtask

    // stalled consumer: two words fit, the third is refused
    task automatic test_full();
        logic [7:0] rx;
        logic       a;
        dataReady = 1'b0;
        u_master.start();
        u_master.xfer(8'h5e, 1'b1, rx, a);
        u_master.xfer(8'h01, 1'b1, rx, a);
        chkBit(1'b0, a);
        u_master.xfer(8'h02, 1'b1, rx, a);
        chkBit(1'b0, a);
        u_master.xfer(8'h03, 1'b1, rx, a);
        chkBit(1'b1, a); // buffer full refuses
        u_master.stop();
        chkData(8'h02, {1'b0, wiperOut});
        dataReady = 1'b1;
        u_master.tick(4);
        chkPops(7'h01, 7'h02);
        chkBit(1'b0, dataValid);
        $display("test full done");
    endtask

    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clock);
        #1 rst_b = 1'b1;
        u_master.tick(4);
        test_reset();
        test_write();
        test_read();
        test_refuse();
        test_abort();
        test_recover();
        test_full();
        end_of_test();
    end

    // watchdog, run needs about 1850 cycles
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        end_of_test();
    end
endmodule // i2c_slave_wiper_port_tb
